/* design/hbs_consts.svh */
// Constants of the half-bridge status and delay readback block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef HBS_CONSTS_SVH
`define HBS_CONSTS_SVH

// Sizes
`define HBS_NUM_HB          8
`define HBS_NUM_CH          2
`define HBS_NUM_PWM         3
`define HBS_ADDR_W          5
`define HBS_DATA_W          16
`define HBS_TH_W            3
`define HBS_CNT_W           8
`define HBS_ACC_W           17

// Register addresses on the five-bit register port
`define HBS_ADDR_STATUS     5'h13
`define HBS_ADDR_DLY1       5'h14
`define HBS_ADDR_DLY2       5'h15

// Field positions
`define HBS_LEVEL_LSB       0
`define HBS_CONFLICT_LSB    8
`define HBS_TON_LSB         0
`define HBS_TOFF_LSB        8

// Reset values
`define HBS_RST_DLY         8'h00
`define HBS_RST_STATUS      16'h0000
`define HBS_RST_BITS8       8'h00
`define HBS_RST_TH          24'h000000

// Drive settings that force the level flag low
`define HBS_DRV_FORCE_A     2'h1
`define HBS_DRV_FORCE_B     2'h2

// Timing: clock period and delay quantum, both in picoseconds
`define HBS_CLK_PERIOD_PS   8000
`define HBS_DLY_STEP_PS     62500
`define HBS_CNT_MAX         8'hFF

`endif

/* design/hbs_level_eval.sv */
// Per-bridge switch-node level flag evaluator.
// Assumes comparator results arrive asynchronously; drive settings are synchronous.
`timescale 1ns/1ps
`include "hbs_consts.svh"

module hbs_level_eval (
   input wire logic    i_clk,
   input wire logic    i_nrst,
   hbs_level_if.eval   bus
);

   logic [`HBS_NUM_HB-1:0] sup_meta_q;
   logic [`HBS_NUM_HB-1:0] sup_sync_q;
   logic [`HBS_NUM_HB-1:0] cs_meta_q;
   logic [`HBS_NUM_HB-1:0] cs_sync_q;
   logic [`HBS_NUM_HB-1:0] level_q;
   logic [`HBS_NUM_HB-1:0] level_d;

   ////////////////////////////////////////////////////////////////////////////
   // Per-bridge flag: reference mux, then forcing by drive setting
   genvar g;
   generate
      for (g = 0; g < `HBS_NUM_HB; g = g + 1) begin : gen_hb
         hbs_pkg::hbs_drive_t drv;
         logic                forced;
         logic                below;
         assign drv    = bus.drive[2*g+1:2*g];
         assign forced = (drv == `HBS_DRV_FORCE_A) || (drv == `HBS_DRV_FORCE_B);
         // Each comparator already uses this bridge's own threshold
         assign below  = bus.ref_sel[g] ? cs_sync_q[g] : sup_sync_q[g];
         assign level_d[g] = forced ? 1'b0 : below;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers, then the flag register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sup_meta_q <= `HBS_RST_BITS8;
         sup_sync_q <= `HBS_RST_BITS8;
         cs_meta_q  <= `HBS_RST_BITS8;
         cs_sync_q  <= `HBS_RST_BITS8;
         level_q    <= `HBS_RST_BITS8;
      end else begin
         sup_meta_q <= bus.sup_raw;
         sup_sync_q <= sup_meta_q;
         cs_meta_q  <= bus.csin_raw;
         cs_sync_q  <= cs_meta_q;
         level_q    <= level_d;
      end
   end

   assign bus.level = level_q;

endmodule

/* design/hbs_level_if.sv */
// Carrier between the top and the per-bridge level evaluator.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
`include "hbs_consts.svh"

interface hbs_level_if;
   logic [2*`HBS_NUM_HB-1:0] drive;
   logic [`HBS_NUM_HB-1:0]   ref_sel;
   logic [`HBS_NUM_HB-1:0]   sup_raw;
   logic [`HBS_NUM_HB-1:0]   csin_raw;
   logic [`HBS_NUM_HB-1:0]   level;

   modport eval (input drive, input ref_sel, input sup_raw, input csin_raw, output level);
   modport ctrl (output drive, output ref_sel, output sup_raw, output csin_raw, input level);
endinterface

/* design/hbs_pkg.sv */
// Types of the half-bridge status and delay readback block.
// Assumes the constants header is on the include path.
`include "hbs_consts.svh"

package hbs_pkg;
   typedef logic [1:0] hbs_drive_t;
   typedef logic [`HBS_CNT_W-1:0] hbs_count_t;
   typedef enum logic [1:0] {
      HBS_IDLE,
      HBS_MEAS_ON,
      HBS_MEAS_OFF
   } hbs_meas_state_t;
endpackage

/* design/hbs_status_regs.sv */
// Half-bridge level status, PWM mapping conflict and effective delay readback.
// Assumes a serial framer on the same clock drives the five-bit register port,
// analog comparators drive the asynchronous compare inputs, and configuration
// inputs come from registers on the same clock.
`timescale 1ns/1ps
`include "hbs_consts.svh"

// Functional notes
// - Level flags of half-bridges one to seven sit in status bits zero to six.
// - With drive (0,0) or (1,1) and reference select 0, the flag is 1 when drain supply to switch node is below threshold.
// - With reference select 1, the flag compares current-sense input one against the switch node instead.
// - Drive settings (0,1) and (1,0) force the level flag to 0.
// - Each bridge compares against its own selected drain-source monitoring threshold.
// - A conflict flag clears only when at most one active PWM channel is mapped to its bridge.
// - Channel 1 turn-off delay reads in bits 15:8 as a count of 62.5 ns units.
// - Channel 1 turn-on delay reads in bits 7:0 as a count of 62.5 ns units.
// - Channel 2 turn-off delay reads in bits 15:8 and turn-on delay in bits 7:0, same unit.
// - All delay fields read zero after reset until a measurement completes.
// - The channel 1 delay register decodes at 10100 and channel 2 at 10101.
// - Status bits 15 to 8 flag more than one active PWM channel mapped to bridges eight to one.
// - The bridge eight level flag sits in bit 7 and behaves like the others.
module hbs_status_regs (
   input  wire logic                            I_SYS_CLK,
   input  wire logic                            I_NRST,
   input  wire logic [`HBS_ADDR_W-1:0]          I_REG_ADDR,
   input  wire logic                            I_REG_RD,
   input  wire logic                            I_REG_WR,
   output logic      [`HBS_DATA_W-1:0]          O_REG_RDATA,
   output logic                                 O_REG_ACK,
   input  wire logic [2*`HBS_NUM_HB-1:0]        I_BRIDGE_DRIVE_SETTING,
   input  wire logic [`HBS_NUM_HB-1:0]          I_SENSE_REFERENCE_SELECT,
   input  wire logic [`HBS_TH_W*`HBS_NUM_HB-1:0] I_DRAIN_SOURCE_MONITOR_THRESHOLD,
   output logic      [`HBS_TH_W*`HBS_NUM_HB-1:0] O_CMP_THRESHOLD,
   input  wire logic [`HBS_NUM_HB-1:0]          I_DRAIN_SUPPLY_BELOW_TH,
   input  wire logic [`HBS_NUM_HB-1:0]          I_CURRENT_SENSE_BELOW_TH,
   input  wire logic [`HBS_NUM_PWM-1:0]         I_PWM_CH_ACTIVE,
   input  wire logic [`HBS_NUM_PWM*`HBS_NUM_HB-1:0] I_PWM_CHANNEL_MAPPING,
   input  wire logic [`HBS_NUM_CH-1:0]          I_PWM_IN,
   input  wire logic [`HBS_NUM_CH-1:0]          I_GATE_SWITCHED
);

   localparam logic [`HBS_ACC_W-1:0] PERIOD_PS = `HBS_ACC_W'(`HBS_CLK_PERIOD_PS);
   localparam logic [`HBS_ACC_W-1:0] STEP_PS   = `HBS_ACC_W'(`HBS_DLY_STEP_PS);

   hbs_level_if lvl_if ();

   logic [`HBS_NUM_HB-1:0]              conflict_q;
   logic [`HBS_NUM_HB-1:0]              conflict_d;
   logic [`HBS_TH_W*`HBS_NUM_HB-1:0]    threshold_q;
   logic [`HBS_DATA_W-1:0]              rdata_q;
   logic [`HBS_DATA_W-1:0]              rdata_d;
   logic                                ack_q;
   logic                                ack_d;
   hbs_pkg::hbs_count_t                 ton_w  [`HBS_NUM_CH];
   hbs_pkg::hbs_count_t                 toff_w [`HBS_NUM_CH];

   ////////////////////////////////////////////////////////////////////////////
   // Level flag evaluator
   assign lvl_if.drive    = I_BRIDGE_DRIVE_SETTING;
   assign lvl_if.ref_sel  = I_SENSE_REFERENCE_SELECT;
   assign lvl_if.sup_raw  = I_DRAIN_SUPPLY_BELOW_TH;
   assign lvl_if.csin_raw = I_CURRENT_SENSE_BELOW_TH;

   hbs_level_eval u_level (
      .i_clk  (I_SYS_CLK),
      .i_nrst (I_NRST),
      .bus    (lvl_if.eval)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Threshold routing: every bridge's comparator gets its own setting
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         threshold_q <= `HBS_RST_TH;
      end else begin
         threshold_q <= I_DRAIN_SOURCE_MONITOR_THRESHOLD;
      end
   end

   assign O_CMP_THRESHOLD = threshold_q;

   ////////////////////////////////////////////////////////////////////////////
   // PWM mapping conflict: count active channels mapped to each bridge
   genvar h;
   generate
      for (h = 0; h < `HBS_NUM_HB; h = h + 1) begin : gen_conf
         logic [1:0] hits;
         assign hits = 2'(I_PWM_CH_ACTIVE[0] & I_PWM_CHANNEL_MAPPING[h])
                     + 2'(I_PWM_CH_ACTIVE[1] & I_PWM_CHANNEL_MAPPING[`HBS_NUM_HB+h])
                     + 2'(I_PWM_CH_ACTIVE[2] & I_PWM_CHANNEL_MAPPING[2*`HBS_NUM_HB+h]);
         // Flag holds while two or more map here, clears at one or none
         assign conflict_d[h] = (hits > 2'h1);
      end
   endgenerate

   // Conflict register
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         conflict_q <= `HBS_RST_BITS8;
      end else begin
         conflict_q <= conflict_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Effective delay measurement, one engine per PWM input, for channels 1 and 2 only.
   // The clock period does not divide 62.5 ns, so a picosecond accumulator
   // carries the remainder instead of a fixed cycle divider.
   genvar c;
   generate
      for (c = 0; c < `HBS_NUM_CH; c = c + 1) begin : gen_ch
         hbs_pkg::hbs_meas_state_t   state_q;
         hbs_pkg::hbs_meas_state_t   state_d;
         logic                       pwm_meta_q;
         logic                       pwm_sync_q;
         logic                       pwm_prev_q;
         logic                       sw_meta_q;
         logic                       sw_sync_q;
         logic [`HBS_ACC_W-1:0]      acc_q;
         logic [`HBS_ACC_W-1:0]      acc_d;
         logic [`HBS_ACC_W-1:0]      acc_sum;
         hbs_pkg::hbs_count_t        cnt_q;
         hbs_pkg::hbs_count_t        cnt_d;
         hbs_pkg::hbs_count_t        cnt_tick;
         logic [`HBS_ACC_W-1:0]      acc_tick;
         hbs_pkg::hbs_count_t        ton_q;
         hbs_pkg::hbs_count_t        ton_d;
         hbs_pkg::hbs_count_t        toff_q;
         hbs_pkg::hbs_count_t        toff_d;
         logic                       rise;
         logic                       fall;

         // Edge detect on the second flop only
         assign rise    = pwm_sync_q & ~pwm_prev_q;
         assign fall    = ~pwm_sync_q & pwm_prev_q;
         assign acc_sum = acc_q + PERIOD_PS;

         // One clock of elapsed time, count saturates at full scale
         always_comb begin
            if (acc_sum >= STEP_PS) begin
               acc_tick = acc_sum - STEP_PS;
               cnt_tick = (cnt_q == `HBS_CNT_MAX) ? cnt_q : cnt_q + 8'h01;
            end else begin
               acc_tick = acc_sum;
               cnt_tick = cnt_q;
            end
         end

         // Measurement sequencer; a new PWM edge restarts the opposite measurement
         always_comb begin
            state_d = state_q;
            acc_d   = acc_tick;
            cnt_d   = cnt_tick;
            ton_d   = ton_q;
            toff_d  = toff_q;
            case (state_q)
               hbs_pkg::HBS_IDLE: begin
                  acc_d = '0;
                  cnt_d = `HBS_RST_DLY;
                  if (rise) begin
                     state_d = hbs_pkg::HBS_MEAS_ON;
                  end else if (fall) begin
                     state_d = hbs_pkg::HBS_MEAS_OFF;
                  end
               end
               hbs_pkg::HBS_MEAS_ON: begin
                  if (fall) begin
                     state_d = hbs_pkg::HBS_MEAS_OFF;
                     acc_d   = '0;
                     cnt_d   = `HBS_RST_DLY;
                  end else if (sw_sync_q) begin
                     ton_d   = cnt_q;
                     state_d = hbs_pkg::HBS_IDLE;
                  end
               end
               hbs_pkg::HBS_MEAS_OFF: begin
                  if (rise) begin
                     state_d = hbs_pkg::HBS_MEAS_ON;
                     acc_d   = '0;
                     cnt_d   = `HBS_RST_DLY;
                  end else if (!sw_sync_q) begin
                     toff_d  = cnt_q;
                     state_d = hbs_pkg::HBS_IDLE;
                  end
               end
               default: begin
                  state_d = hbs_pkg::HBS_IDLE;
                  acc_d   = '0;
                  cnt_d   = `HBS_RST_DLY;
               end
            endcase
         end

         // Registers; results start at zero until a measurement ends
         always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
               state_q    <= hbs_pkg::HBS_IDLE;
               pwm_meta_q <= 1'b0;
               pwm_sync_q <= 1'b0;
               pwm_prev_q <= 1'b0;
               sw_meta_q  <= 1'b0;
               sw_sync_q  <= 1'b0;
               acc_q      <= '0;
               cnt_q      <= `HBS_RST_DLY;
               ton_q      <= `HBS_RST_DLY;
               toff_q     <= `HBS_RST_DLY;
            end else begin
               state_q    <= state_d;
               pwm_meta_q <= I_PWM_IN[c];
               pwm_sync_q <= pwm_meta_q;
               pwm_prev_q <= pwm_sync_q;
               sw_meta_q  <= I_GATE_SWITCHED[c];
               sw_sync_q  <= sw_meta_q;
               acc_q      <= acc_d;
               cnt_q      <= cnt_d;
               ton_q      <= ton_d;
               toff_q     <= toff_d;
            end
         end

         assign ton_w[c]  = ton_q;
         assign toff_w[c] = toff_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Register port: read data registered, writes acknowledged but discarded
   always_comb begin
      rdata_d = rdata_q;
      ack_d   = 1'b0;
      case (I_REG_ADDR)
         `HBS_ADDR_STATUS: begin
            ack_d = I_REG_RD | I_REG_WR;
            if (I_REG_RD) begin
               rdata_d = {conflict_q, lvl_if.level};
            end
         end
         `HBS_ADDR_DLY1: begin
            ack_d = I_REG_RD | I_REG_WR;
            if (I_REG_RD) begin
               rdata_d = {toff_w[0], ton_w[0]};
            end
         end
         `HBS_ADDR_DLY2: begin
            ack_d = I_REG_RD | I_REG_WR;
            if (I_REG_RD) begin
               rdata_d = {toff_w[1], ton_w[1]};
            end
         end
         default: begin
            // Other addresses belong to neighbouring blocks: no answer here
            if (I_REG_RD) begin
               rdata_d = `HBS_RST_STATUS;
            end
         end
      endcase
   end

   // Read port registers
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rdata_q <= `HBS_RST_STATUS;
         ack_q   <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ack_q   <= ack_d;
      end
   end

   assign O_REG_RDATA = rdata_q;
   assign O_REG_ACK   = ack_q;

endmodule

/* tb/hbs_host_model.sv */
// Host side model issuing single register accesses on the five-bit port.
// Assumes a request is taken at one rising edge and answered right after it.
`timescale 1ns/1ps
module hbs_host_model (
   input  wire logic        i_clk,
   output logic      [4:0]  o_addr,
   output logic             o_rd,
   output logic             o_wr,
   input  wire logic [15:0] i_rdata,
   input  wire logic        i_ack
);
   // Idle bus before the first access
   initial begin
      o_addr = 5'h00;
      o_rd = 1'b0;
      o_wr = 1'b0;
   end
   // One-cycle strobe; address held until the answer edge, then inverted so stale values never match
   task automatic access(input logic [4:0] a, input logic w, output logic [15:0] d, output logic k);
      @(posedge i_clk);
      o_addr <= a;
      o_rd   <= !w;
      o_wr   <= w;
      @(posedge i_clk);
      o_rd   <= 1'b0;
      o_wr   <= 1'b0;
      // Answer taken at the edge where the acknowledge stands
      @(posedge i_clk);
      d = i_rdata;
      k = i_ack;
      o_addr <= ~a;
   endtask
endmodule

/* tb/hbs_status_regs_asserts.sv */
// Port-level checks of the status and delay readback block.
// Assumes one clock domain and the constants header on the include path.
`timescale 1ns/1ps
`include "hbs_consts.svh"
module hbs_status_regs_chk (
   input wire logic        I_SYS_CLK,
   input wire logic        I_NRST,
   input wire logic [4:0]  I_REG_ADDR,
   input wire logic        I_REG_RD,
   input wire logic        I_REG_WR,
   input wire logic [15:0] O_REG_RDATA,
   input wire logic        O_REG_ACK,
   input wire logic [15:0] I_BRIDGE_DRIVE_SETTING,
   input wire logic [7:0]  I_SENSE_REFERENCE_SELECT,
   input wire logic [23:0] I_DRAIN_SOURCE_MONITOR_THRESHOLD,
   input wire logic [23:0] O_CMP_THRESHOLD,
   input wire logic [7:0]  I_DRAIN_SUPPLY_BELOW_TH,
   input wire logic [7:0]  I_CURRENT_SENSE_BELOW_TH,
   input wire logic [2:0]  I_PWM_CH_ACTIVE,
   input wire logic [23:0] I_PWM_CHANNEL_MAPPING,
   input wire logic [1:0]  I_PWM_IN
);
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_NRST);
   logic       req, hit, exp1, seen_q, seen_d;
   logic [2:0] stab_q, stab_d;
   logic [4:0] b1, b1_q;
   logic [1:0] pwm_q;
   logic [7:0] conf;
   ////////////////////////////////////////////////////////////
   // Request decode and expected flag of bridge one
   assign req = I_REG_RD | I_REG_WR;
   assign hit = I_REG_ADDR inside {5'h13, 5'h14, 5'h15};
   assign b1 = {I_BRIDGE_DRIVE_SETTING[1:0], I_SENSE_REFERENCE_SELECT[0],
                I_DRAIN_SUPPLY_BELOW_TH[0], I_CURRENT_SENSE_BELOW_TH[0]};
   assign exp1 = (I_BRIDGE_DRIVE_SETTING[1:0] inside {2'h1, 2'h2}) ? 1'b0 :
                 (I_SENSE_REFERENCE_SELECT[0] ? I_CURRENT_SENSE_BELOW_TH[0] : I_DRAIN_SUPPLY_BELOW_TH[0]);
   // More than one active channel per bridge; sums widened so they cannot wrap
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         conf[b] = (2'(I_PWM_CH_ACTIVE[0] & I_PWM_CHANNEL_MAPPING[b])
                  + 2'(I_PWM_CH_ACTIVE[1] & I_PWM_CHANNEL_MAPPING[8+b])
                  + 2'(I_PWM_CH_ACTIVE[2] & I_PWM_CHANNEL_MAPPING[16+b])) > 2'h1;
      end
      stab_d = (b1 == b1_q) ? stab_q + {2'h0, stab_q != 3'h7} : 3'h0;
      seen_d = seen_q | (I_PWM_IN != pwm_q);
   end
   // Stability count lets the level check skip the synchroniser latency
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         stab_q <= 3'h0;
         b1_q   <= 5'h00;
         seen_q <= 1'b0;
         pwm_q  <= 2'h0;
      end else begin
         stab_q <= stab_d;
         b1_q   <= b1;
         seen_q <= seen_d;
         pwm_q  <= I_PWM_IN;
      end
   end
   ////////////////////////////////////////////////////////////
   chk_ack_mapped: assert property (req && hit |=> O_REG_ACK)
      else $error("ack missing after mapped access");
   chk_ack_unmapped: assert property (!(req && hit) |=> !O_REG_ACK)
      else $error("ack without mapped access");
   chk_unmapped_zero: assert property (I_REG_RD && !hit |=> O_REG_RDATA == 16'h0000)
      else $error("unmapped read returned data");
   chk_rdata_hold: assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
      else $error("read data moved without a read");
   chk_delay_zero: assert property (I_REG_RD && I_REG_ADDR inside {5'h14, 5'h15} && !seen_q
      |=> O_REG_RDATA == 16'h0000)
      else $error("delay nonzero before any measurement");
   chk_thr_copy: assert property ($past(I_NRST) |-> O_CMP_THRESHOLD == $past(I_DRAIN_SOURCE_MONITOR_THRESHOLD))
      else $error("threshold copy wrong");
   chk_conflict_bits: assert property (I_REG_RD && I_REG_ADDR == 5'h13 && $past(I_NRST)
      && $stable(I_PWM_CHANNEL_MAPPING) && $stable(I_PWM_CH_ACTIVE) |=> O_REG_RDATA[15:8] == $past(conf))
      else $error("conflict bits wrong");
   chk_level_one: assert property (I_REG_RD && I_REG_ADDR == 5'h13 && stab_q >= 3'h5
      |=> O_REG_RDATA[0] == $past(exp1))
      else $error("bridge one level flag wrong");
   cov_ack: cover property (req && hit ##1 O_REG_ACK);
   cov_conf: cover property (I_REG_RD && I_REG_ADDR == 5'h13 && conf != 8'h00);
   cov_pwm: cover property ($rose(I_PWM_IN[0]));
endmodule

bind hbs_status_regs hbs_status_regs_chk u_chk (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST),
   .I_REG_ADDR(I_REG_ADDR), .I_REG_RD(I_REG_RD), .I_REG_WR(I_REG_WR), .O_REG_RDATA(O_REG_RDATA),
   .O_REG_ACK(O_REG_ACK), .I_BRIDGE_DRIVE_SETTING(I_BRIDGE_DRIVE_SETTING),
   .I_SENSE_REFERENCE_SELECT(I_SENSE_REFERENCE_SELECT),
   .I_DRAIN_SOURCE_MONITOR_THRESHOLD(I_DRAIN_SOURCE_MONITOR_THRESHOLD), .O_CMP_THRESHOLD(O_CMP_THRESHOLD),
   .I_DRAIN_SUPPLY_BELOW_TH(I_DRAIN_SUPPLY_BELOW_TH), .I_CURRENT_SENSE_BELOW_TH(I_CURRENT_SENSE_BELOW_TH),
   .I_PWM_CH_ACTIVE(I_PWM_CH_ACTIVE), .I_PWM_CHANNEL_MAPPING(I_PWM_CHANNEL_MAPPING), .I_PWM_IN(I_PWM_IN));

/* tb/hbs_status_regs_tb_top.sv */
// Self-checking bench of the status and delay readback block.
// Assumes the design, the host model and the checker are compiled first.
`timescale 1ns/1ps
module hbs_status_regs_tb_top;
   typedef struct packed {
      logic [15:0] drv;
      logic [7:0]  sel, sup, cs;
      logic [2:0]  act;
      logic [23:0] map;
      logic [15:0] exp;
   } hbs_row_t;
   logic        clk = 1'b0, nrst = 1'b0, rd, wr, ack, k;
   logic [4:0]  addr;
   logic [15:0] rdata, d, drv = 16'h0000;
   logic [7:0]  sel = 8'h00, sup = 8'h00, cs = 8'h00;
   logic [23:0] thr = 24'h000000, cthr, map = 24'h000000;
   logic [2:0]  act = 3'h0;
   logic [1:0]  pwm = 2'h0, gate = 2'h0;
   int          miscompares = 0, cmp_count = 0;
   hbs_row_t    rows [6];
   // 125 MHz system clock
   always #4 clk = ~clk;
   hbs_status_regs DUT (.I_SYS_CLK(clk), .I_NRST(nrst), .I_REG_ADDR(addr), .I_REG_RD(rd), .I_REG_WR(wr),
      .O_REG_RDATA(rdata), .O_REG_ACK(ack), .I_BRIDGE_DRIVE_SETTING(drv), .I_SENSE_REFERENCE_SELECT(sel),
      .I_DRAIN_SOURCE_MONITOR_THRESHOLD(thr), .O_CMP_THRESHOLD(cthr), .I_DRAIN_SUPPLY_BELOW_TH(sup),
      .I_CURRENT_SENSE_BELOW_TH(cs), .I_PWM_CH_ACTIVE(act), .I_PWM_CHANNEL_MAPPING(map), .I_PWM_IN(pwm),
      .I_GATE_SWITCHED(gate));
   hbs_host_model host (.i_clk(clk), .o_addr(addr), .o_rd(rd), .o_wr(wr), .i_rdata(rdata), .i_ack(ack));
   ////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic complete_run();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   // Access then compare both data and acknowledge
   task automatic acc_chk(input logic [4:0] a, input logic w, input logic [15:0] e, input logic ka);
      host.access(a, w, d, k);
      chk("read data", {8'h00, e}, {8'h00, d});
      chk("acknowledge", {23'h00000, ka}, {23'h00000, k});
   endtask
   // PWM edge, then the gate follows after n cycles; margin keeps count exact
   task automatic meas(input int ch, input logic lvl, input int n);
      @(posedge clk);
      pwm[ch] <= lvl;
      repeat (n) @(posedge clk);
      gate[ch] <= lvl;
      repeat (10) @(posedge clk);
   endtask
   // Hang guard
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      rows = '{'{16'h0000, 8'h00, 8'hA5, 8'h5A, 3'h0, 24'h000000, 16'h00A5},
               '{16'hFFFF, 8'hFF, 8'hA5, 8'h5A, 3'h0, 24'h000000, 16'h005A},
               '{16'h5555, 8'h00, 8'hFF, 8'hFF, 3'h7, 24'h000000, 16'h0000},
               '{16'hAAAA, 8'hFF, 8'hFF, 8'hFF, 3'h0, 24'h000000, 16'h0000},
               '{16'h0000, 8'h0F, 8'hF0, 8'h0F, 3'h7, 24'h800181, 16'h81FF},
               '{16'h0001, 8'h00, 8'hFF, 8'h00, 3'h6, 24'h800181, 16'h00FE}};
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      acc_chk(5'h14, 1'b0, 16'h0000, 1'b1);
      acc_chk(5'h15, 1'b0, 16'h0000, 1'b1);
      // Status table: levels, forcing, reference select and conflicts
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         drv <= rows[i].drv;
         sel <= rows[i].sel;
         sup <= rows[i].sup;
         cs  <= rows[i].cs;
         act <= rows[i].act;
         map <= rows[i].map;
         thr <= 24'hFAC688 ^ 24'(i);
         repeat (6) @(posedge clk);
         acc_chk(5'h13, 1'b0, rows[i].exp, 1'b1);
         chk("threshold copy", thr, cthr);
      end
      // Delays: 129 and 68 cycles give 16 and 8 steps, 20 gives 2, 2100 saturates
      meas(0, 1'b1, 129);
      meas(0, 1'b0, 68);
      meas(1, 1'b1, 20);
      meas(1, 1'b0, 2100);
      acc_chk(5'h14, 1'b0, 16'h0810, 1'b1);
      acc_chk(5'h15, 1'b0, 16'hFF02, 1'b1);
      // Writes are acknowledged but change nothing
      acc_chk(5'h14, 1'b1, 16'hFF02, 1'b1);
      acc_chk(5'h13, 1'b1, 16'hFF02, 1'b1);
      acc_chk(5'h14, 1'b0, 16'h0810, 1'b1);
      // Unmapped neighbours give no answer
      acc_chk(5'h16, 1'b0, 16'h0000, 1'b0);
      acc_chk(5'h12, 1'b1, 16'h0000, 1'b0);
      // Second reset in mid-run clears measured delays
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      acc_chk(5'h14, 1'b0, 16'h0000, 1'b1);
      acc_chk(5'h15, 1'b0, 16'h0000, 1'b1);
      complete_run();
   end
endmodule
